// File: logic/iss_pkg.sv
// package for the image sensor sequencer configuration block
`default_nettype none
package iss_pkg;
   // register addresses (upload word bits 15:12)
   localparam logic [3:0] ADDR_TIMING   = 4'h0;
   localparam logic [3:0] ADDR_PIXELS   = 4'h1;
   localparam logic [3:0] ADDR_LINES    = 4'h2;
   localparam logic [3:0] ADDR_EXPOSURE = 4'h3;
   localparam logic [3:0] ADDR_COLSTART = 4'h4;
   localparam logic [3:0] ADDR_RDSTART  = 4'h5;
   localparam logic [3:0] ADDR_RSTSTART = 4'h6;
   localparam logic [3:0] ADDR_ARRAY    = 4'h7;
   localparam logic [3:0] ADDR_AMP      = 4'h8;
   localparam logic [3:0] ADDR_COARSE   = 4'h9;
   localparam logic [3:0] ADDR_FINE     = 4'ha;
   localparam logic [3:0] ADDR_CONV     = 4'hb;
   // upload word layout
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int DATA_MSB = 11;
   // timing control field positions
   localparam int TC_ROLLING   = 0;
   localparam int TC_GRAN_SS   = 6;
   localparam int TC_KNEE      = 8;
   localparam int TC_KNEE_EN   = 10;
   localparam int TC_EXT_RESET = 11;
   // amplifier field positions
   localparam int AMP_UNITY   = 4;
   localparam int AMP_DUAL    = 5;
   localparam int AMP_STANDBY = 6;
   // converter field positions
   localparam int CONV_DRIVE  = 0;
   localparam int CONV_LINEAR = 1;
   localparam int CONV_INVERT = 2;
   // every register reads zero after power-on
   localparam logic [11:0] REG_RESET = 12'h000;
   // shutter granularity base: 32 system clocks
   localparam int GRAN_BASE_LOG2 = 5;
   // time-out pulse lasts one granulated period, or until a stop pulse
   localparam int TIMEOUT_TICKS = 1;

   typedef struct packed {
      logic [11:0] timing;
      logic [11:0] pixels;
      logic [11:0] lines;
      logic [11:0] exposure;
      logic [10:0] col_start;
      logic [10:0] rd_start;
      logic [10:0] rst_start;
      logic [7:0]  array_cfg;
      logic [6:0]  amp;
      logic [6:0]  coarse;
      logic [6:0]  fine;
      logic [2:0]  conv;
   } iss_regs_t;

   typedef enum logic [1:0] {
      LEVEL_LEFT,
      LEVEL_STEP1,
      LEVEL_STEP2,
      LEVEL_STEP3
   } iss_reset_level_t;

   typedef enum logic [1:0] {
      SS_IDLE,
      SS_COUNT,
      SS_TIMEOUT
   } iss_shutter_state_t;
endpackage
`default_nettype wire

// File: logic/iss_sequencer.sv
// image sensor readout sequencer: registers, counters, pointer syncs
//
// Overview of operation
// - knee enable moves reset to right side
// - knee code selects reset level in steps
// - external level bit disables internal generator
// - pixel valid from row clock to count
// - line counter per row clock, last-line flag held until next row clock
// - global shutter exposure count then time-out pulse
// - twelve-bit exposure, coarsest step 256 clocks
// - frame start loads read pointer in rolling
// - row clock advances pointers, loads reset pointer
// - exposure counter clears on read pointer sync
// - column start 640 pairs, even when subsampled
// - test bits tie even or odd columns
// - array bits select horizontal, vertical subsampling
// - gain effective only when unity clear
// - dual output and standby control
// - seven-bit coarse and fine black offsets
// - converter drive enable and linear curve
// - upload word: address 15:12, data 11:0
// - all registers zero after power-on
`default_nettype none
module iss_sequencer #(
   parameter int GRAN_MAX_LOG2 = 3
) (
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [15:0] upload_word_i,
   input  wire logic        upload_strobe_i,
   input  wire logic        frame_start_i,
   input  wire logic        row_clock_i,
   input  wire logic        shutter_start_i,
   input  wire logic        shutter_stop_i,
   output logic             pixel_valid_o,
   output logic             last_line_o,
   output logic             time_out_o,
   output logic             read_pointer_load_o,
   output logic             reset_pointer_load_o,
   output logic [10:0]      read_row_o,
   output logic [10:0]      reset_row_o,
   output logic [9:0]       column_start_o,
   output logic             right_side_reset_o,
   output logic [1:0]       reset_level_sel_o,
   output logic             reset_gen_enable_o,
   output logic             external_reset_level_select_o,
   output logic             test_even_o,
   output logic             test_odd_o,
   output logic [2:0]       h_subsample_o,
   output logic [2:0]       v_subsample_o,
   output logic [3:0]       amp_gain_o,
   output logic             amp_unity_o,
   output logic             second_path_on_o,
   output logic             amp_powered_o,
   output logic [6:0]       coarse_offset_o,
   output logic [6:0]       fine_offset_o,
   output logic             converter_drive_on_o,
   output logic             converter_linear_o,
   output logic             converter_invert_o
);

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [15:0] word_s1;
   logic [15:0] word_s2;
   logic [4:0]  pin_s1;
   logic [4:0]  pin_s2;
   logic [4:0]  pin_d;
   logic [4:0]  pin_rise;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         word_s1 <= 16'h0000;
         word_s2 <= 16'h0000;
         pin_s1  <= 5'h00;
         pin_s2  <= 5'h00;
         pin_d   <= 5'h00;
      end else begin
         word_s1 <= upload_word_i;
         word_s2 <= word_s1;
         pin_s1  <= {shutter_stop_i, shutter_start_i, row_clock_i,
                     frame_start_i, upload_strobe_i};
         pin_s2  <= pin_s1;
         pin_d   <= pin_s2;
      end
   end

   assign pin_rise = pin_s2 & ~pin_d;

   logic up_stb;
   logic frame_stb;
   logic row_stb;
   logic ss_start;
   logic ss_stop;
   assign up_stb    = pin_rise[0];
   assign frame_stb = pin_rise[1];
   assign row_stb   = pin_rise[2];
   assign ss_start  = pin_rise[3];
   assign ss_stop   = pin_rise[4];

   // ==========================================================
   // register upload
   // ==========================================================
   iss_pkg::iss_regs_t regs;
   logic [3:0]  up_addr;
   logic [11:0] up_data;
   assign up_addr = word_s2[iss_pkg::ADDR_MSB:iss_pkg::ADDR_LSB];
   assign up_data = word_s2[iss_pkg::DATA_MSB:0];

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         regs <= '0;
      end else if (up_stb) begin
         if (up_addr == iss_pkg::ADDR_TIMING) begin
            regs.timing <= up_data;
         end else if (up_addr == iss_pkg::ADDR_PIXELS) begin
            regs.pixels <= up_data;
         end else if (up_addr == iss_pkg::ADDR_LINES) begin
            regs.lines <= up_data;
         end else if (up_addr == iss_pkg::ADDR_EXPOSURE) begin
            regs.exposure <= up_data;
         end else if (up_addr == iss_pkg::ADDR_COLSTART) begin
            regs.col_start <= up_data[10:0];
         end else if (up_addr == iss_pkg::ADDR_RDSTART) begin
            regs.rd_start <= up_data[10:0];
         end else if (up_addr == iss_pkg::ADDR_RSTSTART) begin
            regs.rst_start <= up_data[10:0];
         end else if (up_addr == iss_pkg::ADDR_ARRAY) begin
            regs.array_cfg <= up_data[7:0];
         end else if (up_addr == iss_pkg::ADDR_AMP) begin
            regs.amp <= up_data[6:0];
         end else if (up_addr == iss_pkg::ADDR_COARSE) begin
            regs.coarse <= up_data[6:0];
         end else if (up_addr == iss_pkg::ADDR_FINE) begin
            regs.fine <= up_data[6:0];
         end else if (up_addr == iss_pkg::ADDR_CONV) begin
            regs.conv <= up_data[2:0];
         end
      end
   end

   logic rolling;
   assign rolling = regs.timing[iss_pkg::TC_ROLLING];

   // ==========================================================
   // pixel counter and valid
   // ==========================================================
   logic [11:0] pix_cnt;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pix_cnt       <= 12'h000;
         pixel_valid_o <= 1'b0;
      end else if (row_stb) begin
         pix_cnt       <= 12'h000;
         pixel_valid_o <= 1'b1;
      end else if (pixel_valid_o) begin
         if (pix_cnt == regs.pixels) begin
            pixel_valid_o <= 1'b0;
         end else begin
            pix_cnt <= pix_cnt + 12'h001;
         end
      end
   end

   // ==========================================================
   // line counter and last-line flag
   // ==========================================================
   logic [11:0] line_cnt;
   logic        frame_on;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_cnt    <= 12'h000;
         frame_on    <= 1'b0;
         last_line_o <= 1'b0;
      end else if (frame_stb) begin
         // preset so the first row after frame start counts zero
         line_cnt    <= 12'hfff;
         frame_on    <= 1'b1;
         last_line_o <= 1'b0;
      end else if (row_stb && frame_on) begin
         line_cnt    <= line_cnt + 12'h001;
         last_line_o <= (line_cnt + 12'h001) == regs.lines;
      end
   end

   // ==========================================================
   // global shutter exposure timer
   // ==========================================================
   logic [1:0]  gran_sel;
   logic [12:0] gran_cnt;
   logic [12:0] gran_top;
   logic        gran_tick;
   logic [11:0] exp_cnt;
   iss_pkg::iss_shutter_state_t ss_state;

   assign gran_sel = regs.timing[iss_pkg::TC_GRAN_SS +: 2];
   assign gran_top = 13'((1 << (iss_pkg::GRAN_BASE_LOG2
                     + int'(gran_sel))) - 1);
   assign gran_tick = (gran_cnt == gran_top);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gran_cnt <= 13'h0000;
      end else if (ss_start || gran_tick) begin
         gran_cnt <= 13'h0000;
      end else begin
         gran_cnt <= gran_cnt + 13'h0001;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ss_state   <= iss_pkg::SS_IDLE;
         exp_cnt    <= 12'h000;
         time_out_o <= 1'b0;
      end else begin
         case (ss_state)
            iss_pkg::SS_IDLE: begin
               time_out_o <= 1'b0;
               if (ss_start && !rolling) begin
                  exp_cnt  <= 12'h000;
                  ss_state <= iss_pkg::SS_COUNT;
               end
            end
            iss_pkg::SS_COUNT: begin
               if (ss_stop) begin
                  ss_state <= iss_pkg::SS_IDLE;
               end else if (gran_tick) begin
                  if (exp_cnt + 12'h001 == regs.exposure) begin
                     time_out_o <= 1'b1;
                     ss_state   <= iss_pkg::SS_TIMEOUT;
                  end
                  exp_cnt <= exp_cnt + 12'h001;
               end
            end
            iss_pkg::SS_TIMEOUT: begin
               if (gran_tick || ss_stop) begin
                  time_out_o <= 1'b0;
                  ss_state   <= iss_pkg::SS_IDLE;
               end
            end
            default: begin
               ss_state <= iss_pkg::SS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // rolling shutter row pointers
   // ==========================================================
   logic [11:0] roll_cnt;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         roll_cnt             <= 12'h000;
         read_row_o           <= 11'h000;
         reset_row_o          <= 11'h000;
         read_pointer_load_o  <= 1'b0;
         reset_pointer_load_o <= 1'b0;
      end else begin
         read_pointer_load_o  <= 1'b0;
         reset_pointer_load_o <= 1'b0;
         if (rolling && frame_stb) begin
            read_pointer_load_o <= 1'b1;
            read_row_o          <= regs.rd_start;
            roll_cnt            <= 12'h000;
         end else if (rolling && row_stb) begin
            read_row_o <= read_row_o + 11'h001;
            roll_cnt   <= roll_cnt + 12'h001;
            if (roll_cnt + 12'h001 == regs.exposure) begin
               reset_pointer_load_o <= 1'b1;
               reset_row_o          <= regs.rst_start;
            end else begin
               reset_row_o <= reset_row_o + 11'h001;
            end
         end else if (!rolling && frame_stb) begin
            read_row_o <= regs.rd_start;
         end
      end
   end

   // ==========================================================
   // static configuration outputs
   // ==========================================================
   logic [1:0] knee;
   logic       knee_en;
   assign knee    = regs.timing[iss_pkg::TC_KNEE +: 2];
   assign knee_en = regs.timing[iss_pkg::TC_KNEE_EN];

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         column_start_o                <= 10'h000;
         right_side_reset_o            <= 1'b0;
         reset_level_sel_o             <= 2'h0;
         reset_gen_enable_o            <= 1'b0;
         external_reset_level_select_o <= 1'b0;
         test_even_o                   <= 1'b0;
         test_odd_o                    <= 1'b0;
         h_subsample_o                 <= 3'h0;
         v_subsample_o                 <= 3'h0;
         amp_gain_o                    <= 4'h0;
         amp_unity_o                   <= 1'b0;
         second_path_on_o              <= 1'b0;
         amp_powered_o                 <= 1'b0;
         coarse_offset_o               <= 7'h00;
         fine_offset_o                 <= 7'h00;
         converter_drive_on_o          <= 1'b0;
         converter_linear_o            <= 1'b0;
         converter_invert_o            <= 1'b0;
      end else begin
         // subsampled starts forced even, max 1022
         column_start_o <= regs.array_cfg[2] ?
                           {regs.col_start[9:1], 1'b0} :
                           regs.col_start[9:0];
         right_side_reset_o <= knee_en;
         reset_level_sel_o  <= knee_en ? knee :
                               2'(iss_pkg::LEVEL_LEFT);
         reset_gen_enable_o <= ~regs.timing[iss_pkg::TC_EXT_RESET];
         external_reset_level_select_o <=
            regs.timing[iss_pkg::TC_EXT_RESET];
         test_even_o   <= regs.array_cfg[0];
         test_odd_o    <= regs.array_cfg[1];
         h_subsample_o <= regs.array_cfg[4:2];
         v_subsample_o <= regs.array_cfg[7:5];
         amp_unity_o   <= regs.amp[iss_pkg::AMP_UNITY];
         amp_gain_o    <= regs.amp[iss_pkg::AMP_UNITY] ? 4'h0 :
                          regs.amp[3:0];
         amp_powered_o <= regs.amp[iss_pkg::AMP_STANDBY];
         second_path_on_o <= regs.amp[iss_pkg::AMP_STANDBY] &
                             regs.amp[iss_pkg::AMP_DUAL];
         coarse_offset_o <= regs.coarse;
         fine_offset_o   <= regs.fine;
         converter_drive_on_o <= regs.conv[iss_pkg::CONV_DRIVE];
         converter_linear_o   <= regs.conv[iss_pkg::CONV_LINEAR];
         converter_invert_o   <= regs.conv[iss_pkg::CONV_INVERT];
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   sequence s_row_start;
      row_stb;
   endsequence

   a_valid_rises: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      s_row_start |=> pixel_valid_o)
      else $error("pixel valid not raised after row start");

   a_valid_falls: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (pixel_valid_o && !row_stb && pix_cnt == regs.pixels)
      |=> !pixel_valid_o)
      else $error("pixel valid not lowered at count");

   a_last_line: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (row_stb && frame_on && !frame_stb
       && line_cnt + 12'h001 == regs.lines) |=> last_line_o)
      else $error("last line missing");

   a_timeout_len: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      $rose(time_out_o) |-> ##[1:300] !time_out_o)
      else $error("time-out pulse too long");

   a_read_load: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (rolling && frame_stb) |=>
      (read_pointer_load_o && read_row_o == $past(regs.rd_start)))
      else $error("read pointer not loaded");

   a_reset_load: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (rolling && row_stb && !frame_stb
       && roll_cnt + 12'h001 == regs.exposure)
      |=> reset_pointer_load_o)
      else $error("reset pointer not loaded");

   a_count_clear: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      (rolling && frame_stb) |=> roll_cnt == 12'h000)
      else $error("exposure counter not cleared");

   a_knee_right: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      right_side_reset_o == $past(knee_en)
      && reset_level_sel_o == ($past(knee_en) ? $past(knee) : 2'h0))
      else $error("level selected without right side");

   a_gain_unity: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      amp_unity_o |-> amp_gain_o == 4'h0)
      else $error("gain active in unity mode");

   a_second_path: assert property (
      @(posedge core_clk_i) disable iff (!resetn_i)
      second_path_on_o |-> amp_powered_o)
      else $error("second path on while powered down");

endmodule
`default_nettype wire

// File: verif/iss_controller.sv
// external controller model: register uploads and sequencer pulses
`default_nettype none
module iss_controller (
   input  wire logic        core_clk_i,
   input  wire logic        time_out_i,
   output var  logic [15:0] upload_word_o,
   output var  logic        upload_strobe_o,
   output var  logic        frame_start_o,
   output var  logic        row_clock_o,
   output var  logic        shutter_start_o,
   output var  logic        shutter_stop_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      upload_word_o   = 16'h0000;
      upload_strobe_o = 1'b0;
      frame_start_o   = 1'b0;
      row_clock_o     = 1'b0;
      shutter_start_o = 1'b0;
      shutter_stop_o  = 1'b0;
   end

   // ==========================================
   // register upload, word line scrambled once released
   task automatic upload(input logic [3:0] a, input logic [11:0] d);
      @(negedge core_clk_i);
      upload_word_o = {a, d};
      repeat (2) @(negedge core_clk_i);
      upload_strobe_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      upload_strobe_o = 1'b0;
      repeat (3) @(negedge core_clk_i);
      upload_word_o = ~upload_word_o;
      repeat (4) @(negedge core_clk_i);
   endtask

   // ==========================================
   // sequencer pulse: 0 frame start, 1 row clock, 2 shutter start
   task automatic pulse(input int which, input int width);
      @(negedge core_clk_i);
      case (which)
         0: frame_start_o = 1'b1;
         1: row_clock_o = 1'b1;
         default: shutter_start_o = 1'b1;
      endcase
      repeat (width) @(negedge core_clk_i);
      frame_start_o   = 1'b0;
      row_clock_o     = 1'b0;
      shutter_start_o = 1'b0;
      repeat (8) @(negedge core_clk_i);
   endtask

   // ==========================================
   // time-out answered with a stop pulse
   always begin
      @(posedge time_out_i);
      @(negedge core_clk_i);
      shutter_stop_o = 1'b1;
      repeat (2) @(negedge core_clk_i);
      shutter_stop_o = 1'b0;
   end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the sequencer configuration block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk_i, resetn_i, upload_strobe_i;
   logic [15:0] upload_word_i;
   logic        frame_start_i, row_clock_i, shutter_start_i, shutter_stop_i;
   logic        pixel_valid_o, last_line_o, time_out_o;
   logic        read_pointer_load_o, reset_pointer_load_o;
   logic [10:0] read_row_o, reset_row_o;
   logic [9:0]  column_start_o;
   logic [1:0]  reset_level_sel_o;
   logic [2:0]  h_subsample_o, v_subsample_o;
   logic [3:0]  amp_gain_o;
   logic [6:0]  coarse_offset_o, fine_offset_o;
   logic        right_side_reset_o, reset_gen_enable_o;
   logic        external_reset_level_select_o, test_even_o, test_odd_o;
   logic        amp_unity_o, second_path_on_o, amp_powered_o;
   logic        converter_drive_on_o, converter_linear_o, converter_invert_o;
   int          num_errors, comparisons, n_rd, n_rst, n_pix, t;

   iss_sequencer u_iss_sequencer (
      .core_clk_i, .resetn_i, .upload_word_i, .upload_strobe_i,
      .frame_start_i, .row_clock_i, .shutter_start_i, .shutter_stop_i,
      .pixel_valid_o, .last_line_o, .time_out_o, .read_pointer_load_o,
      .reset_pointer_load_o, .read_row_o, .reset_row_o, .column_start_o,
      .right_side_reset_o, .reset_level_sel_o, .reset_gen_enable_o,
      .external_reset_level_select_o, .test_even_o, .test_odd_o,
      .h_subsample_o, .v_subsample_o, .amp_gain_o, .amp_unity_o,
      .second_path_on_o, .amp_powered_o, .coarse_offset_o, .fine_offset_o,
      .converter_drive_on_o, .converter_linear_o, .converter_invert_o
   );

   iss_controller u_iss_controller (
      .core_clk_i, .time_out_i(time_out_o), .upload_word_o(upload_word_i),
      .upload_strobe_o(upload_strobe_i), .frame_start_o(frame_start_i),
      .row_clock_o(row_clock_i), .shutter_start_o(shutter_start_i),
      .shutter_stop_o(shutter_stop_i)
   );

   initial core_clk_i = 1'b0;
   always #20 core_clk_i = ~core_clk_i;

   // ==========================================
   // pulse and valid-cycle counters, sampled mid-cycle
   always @(negedge core_clk_i) begin
      if (read_pointer_load_o === 1'b1) n_rd++;
      if (reset_pointer_load_o === 1'b1) n_rst++;
      if (pixel_valid_o === 1'b1) n_pix++;
   end

   // ==========================================
   task automatic complete_run();
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // outputs derived from one register
   function automatic logic [15:0] view(input logic [3:0] a);
      case (a)
         iss_pkg::ADDR_TIMING: return 16'({right_side_reset_o,
            reset_level_sel_o, reset_gen_enable_o,
            external_reset_level_select_o});
         iss_pkg::ADDR_ARRAY: return 16'({test_even_o, test_odd_o,
            h_subsample_o, v_subsample_o});
         iss_pkg::ADDR_COLSTART: return 16'(column_start_o);
         iss_pkg::ADDR_AMP: return 16'({amp_gain_o, amp_unity_o,
            second_path_on_o, amp_powered_o});
         iss_pkg::ADDR_COARSE: return 16'(coarse_offset_o);
         iss_pkg::ADDR_FINE: return 16'(fine_offset_o);
         iss_pkg::ADDR_CONV: return 16'({converter_drive_on_o,
            converter_linear_o, converter_invert_o});
         default: return 16'h0000;
      endcase
   endfunction

   task automatic cfg(input logic [3:0] a, input logic [11:0] d,
                      input logic [15:0] e);
      u_iss_controller.upload(a, d);
      chk(32'(view(a)), 32'(e));
   endtask

   // bounded wait for a time-out level, cycles returned in t
   task automatic wait_to(input logic v, input int lim);
      t = 0;
      while (time_out_o !== v) begin
         @(negedge core_clk_i);
         t++;
         if (t > lim) begin
            num_errors++;
            $display("Error %0t: time-out wait expired", $time);
            complete_run();
         end
      end
   endtask

   // global shutter exposure at granularity g
   task automatic shot(input int g);
      int p;
      p = 32 << g;
      u_iss_controller.upload(iss_pkg::ADDR_TIMING, 12'(g << 6));
      u_iss_controller.pulse(2, 2);
      wait_to(1'b1, 4000);
      chk(32'(t + 10 >= 10 * p && t + 10 <= 12 * p + 16), 1);
      wait_to(1'b0, p + 8);
      repeat (8) @(negedge core_clk_i);
   endtask

   // rolling frame: read sync, ten rows, reset sync
   task automatic frame(input int k);
      u_iss_controller.pulse(0, 3);
      chk(n_rd, k);
      chk(32'(read_row_o), 100);
      for (int i = 1; i <= 10; i++) begin
         u_iss_controller.pulse(1, 1);
         if (i >= 3 && i <= 5) chk(32'(last_line_o), i == 4);
         if (i == 9) begin
            chk(n_rst, k - 1);
            chk(32'(read_row_o), 109);
            if (k == 2) chk(32'(reset_row_o), 109);
         end
      end
      chk(n_rst, k);
      chk(32'(reset_row_o), 100);
      chk(n_pix, 60 * k);
   endtask

   // ==========================================
   initial begin
      resetn_i = 1'b0;
      repeat (8) @(negedge core_clk_i);
      resetn_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk({pixel_valid_o, last_line_o, time_out_o, column_start_o,
           amp_gain_o, coarse_offset_o, fine_offset_o}, 0);
      for (int k = 0; k < 4; k++) begin
         cfg(iss_pkg::ADDR_TIMING, 12'h400 | 12'(k << 8),
             16'({1'b1, 2'(k), 2'b10}));
      end
      cfg(iss_pkg::ADDR_TIMING, 12'h900, 16'h0001);
      cfg(iss_pkg::ADDR_ARRAY, 12'h0a5, 16'h008d);
      cfg(iss_pkg::ADDR_COLSTART, 12'h27f, 16'h027e);
      cfg(iss_pkg::ADDR_ARRAY, 12'h002, 16'h0040);
      chk(32'(column_start_o), 639);
      cfg(iss_pkg::ADDR_AMP, 12'h075, 16'h0007);
      cfg(iss_pkg::ADDR_AMP, 12'h045, 16'h0029);
      cfg(iss_pkg::ADDR_AMP, 12'h025, 16'h0028);
      cfg(iss_pkg::ADDR_COARSE, 12'h07f, 16'h007f);
      cfg(iss_pkg::ADDR_COARSE, 12'h000, 16'h0000);
      cfg(iss_pkg::ADDR_FINE, 12'h040, 16'h0040);
      cfg(iss_pkg::ADDR_CONV, 12'h003, 16'h0006);
      cfg(iss_pkg::ADDR_CONV, 12'h004, 16'h0001);
      u_iss_controller.upload(4'hc, 12'hfff);
      chk(32'({view(iss_pkg::ADDR_CONV), view(iss_pkg::ADDR_AMP)}),
          32'h00010028);
      u_iss_controller.upload(iss_pkg::ADDR_PIXELS, 12'h005);
      u_iss_controller.upload(iss_pkg::ADDR_LINES, 12'h003);
      u_iss_controller.upload(iss_pkg::ADDR_EXPOSURE, 12'h00a);
      u_iss_controller.upload(iss_pkg::ADDR_RDSTART, 12'h064);
      u_iss_controller.upload(iss_pkg::ADDR_RSTSTART, 12'h064);
      for (int g = 0; g < 4; g++) shot(g);
      u_iss_controller.upload(iss_pkg::ADDR_TIMING, 12'h201);
      u_iss_controller.pulse(2, 2);
      t = 0;
      repeat (500) begin
         @(negedge core_clk_i);
         if (time_out_o !== 1'b0) t++;
      end
      chk(t, 0);
      frame(1);
      frame(2);
      complete_run();
   end
endmodule
`default_nettype wire
